// ===== dcwi_framer.sv
// Splits the host byte stream into address, sign and control word
`timescale 1ns/1ps
`default_nettype none
module dcwi_framer (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Configuration
    input wire logic i_en,
    input wire logic [7:0] i_unit_addr,
    // Received bytes
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    // Completed frame
    output logic o_word_valid,
    output logic [7:0] o_word,
    output logic o_addr_ok,
    output logic o_sign_ok
);
    dcwi_pkg::dcwi_frame_t st_q, st_d;
    logic addr_ok_q, addr_ok_d;
    logic sign_ok_q, sign_ok_d;
    logic word_valid_d;
    logic [7:0] word_d;

    // Fixed three-byte frame: no resync byte exists, so framing relies on the host
    always_comb begin
        st_d = st_q;
        addr_ok_d = addr_ok_q;
        sign_ok_d = sign_ok_q;
        word_valid_d = 1'b0;
        word_d = o_word;
        if (!i_en) begin
            st_d = dcwi_pkg::FR_ADDR;
        end else if (i_rx_valid) begin
            unique case (st_q)
                dcwi_pkg::FR_ADDR: begin
                    addr_ok_d = (i_rx_data == i_unit_addr);
                    st_d = dcwi_pkg::FR_SIGN;
                end
                dcwi_pkg::FR_SIGN: begin
                    sign_ok_d = (i_rx_data == dcwi_pkg::CTRL_SIGN);
                    st_d = dcwi_pkg::FR_WORD;
                end
                dcwi_pkg::FR_WORD: begin
                    word_valid_d = 1'b1;
                    word_d = i_rx_data;
                    st_d = dcwi_pkg::FR_ADDR;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_q <= dcwi_pkg::FR_ADDR;
            addr_ok_q <= 1'b0;
            sign_ok_q <= 1'b0;
            o_word_valid <= 1'b0;
            o_word <= 8'h00;
        end else begin
            st_q <= st_d;
            addr_ok_q <= addr_ok_d;
            sign_ok_q <= sign_ok_d;
            o_word_valid <= word_valid_d;
            o_word <= word_d;
        end
    end

    assign o_addr_ok = addr_ok_q;
    assign o_sign_ok = sign_ok_q;
endmodule // dcwi_framer
`default_nettype wire

// ===== dcwi_host.sv
// Host PC model that sends control word frames over the byte link
`timescale 1ns/1ps
`default_nettype none
module dcwi_host (
    // Clock
    input wire logic i_mclk,
    // Byte link towards the block
    output logic o_rx_valid,
    output logic [7:0] o_rx_data
);
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
    end
    // Setpoints before words 1 2 3 H R O live in variable frames, outside this model
    task automatic send(input logic [7:0] a, input logic [7:0] s, input logic [7:0] w);
        logic [7:0] b [3];
        b = '{a, s, w};
        for (int k = 0; k < 3; k++) begin
            @(posedge i_mclk);
            o_rx_valid <= 1'b1;
            o_rx_data <= b[k];
        end
        // Idle data is the inverted word so nothing latches a stale byte by luck
        @(posedge i_mclk);
        o_rx_valid <= 1'b0;
        o_rx_data <= ~w;
    endtask
endmodule // dcwi_host
`default_nettype wire

// ===== dcwi_irq.sv
// Sticky event status with mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module dcwi_irq #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Events and software access
    input wire logic [W-1:0] i_set,
    input wire logic i_clr_we,
    input wire logic i_mask_we,
    input wire logic [W-1:0] i_wdata,
    // State
    output logic [W-1:0] o_stat,
    output logic [W-1:0] o_mask,
    output logic o_irq
);
    logic [W-1:0] stat_d;
    logic [W-1:0] mask_d;
    logic irq_d;

    // Set wins over a clear in the same cycle so no event is lost
    always_comb begin
        stat_d = (o_stat & ~(i_clr_we ? i_wdata : '0)) | i_set;
        mask_d = i_mask_we ? i_wdata : o_mask;
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_stat <= '0;
            o_mask <= '0;
            o_irq <= 1'b0;
        end else begin
            o_stat <= stat_d;
            o_mask <= mask_d;
            o_irq <= irq_d;
        end
    end
endmodule // dcwi_irq
`default_nettype wire

// ===== dcwi_pkg.sv
// Constants and types for the dyno control word interpreter
package dcwi_pkg;
    // Frame bytes and replies
    localparam logic [7:0] UNIT_ADDR_RST = 8'hb4;
    localparam logic [7:0] CTRL_SIGN = 8'h11;
    localparam logic [7:0] REPLY_ACK = 8'h06;
    localparam logic [7:0] REPLY_NAK = 8'h15;
    localparam logic [7:0] FLAG_FALSE = 8'h00;
    localparam logic [7:0] FLAG_TRUE = 8'h01;
    // Control word characters
    localparam logic [7:0] W_REG_OFF = 8'h30;
    localparam logic [7:0] W_SPEED = 8'h31;
    localparam logic [7:0] W_TORQUE = 8'h32;
    localparam logic [7:0] W_ROAD = 8'h33;
    localparam logic [7:0] W_STEADY = 8'h34;
    localparam logic [7:0] W_BEAM_UP = 8'h35;
    localparam logic [7:0] W_BEAM_DN = 8'h36;
    localparam logic [7:0] W_REST_UP = 8'h37;
    localparam logic [7:0] W_REST_DN = 8'h38;
    localparam logic [7:0] W_DIST_RST = 8'h39;
    localparam logic [7:0] W_AUG_ON = 8'h41;
    localparam logic [7:0] W_AUG_OFF = 8'h42;
    localparam logic [7:0] W_REST_STOP = 8'h47;
    localparam logic [7:0] W_SW1_ON = 8'h48;
    localparam logic [7:0] W_SW1_OFF = 8'h49;
    localparam logic [7:0] W_MOTOR_ON = 8'h4a;
    localparam logic [7:0] W_MOTOR_OFF = 8'h4b;
    localparam logic [7:0] W_CAL_ZERO = 8'h4c;
    localparam logic [7:0] W_CAL_GAIN = 8'h4d;
    localparam logic [7:0] W_CAL_STORE = 8'h4e;
    localparam logic [7:0] W_BTEST_ON = 8'h4f;
    localparam logic [7:0] W_BTEST_OFF = 8'h50;
    localparam logic [7:0] W_VARLOAD = 8'h51;
    localparam logic [7:0] W_SW2_ON = 8'h52;
    localparam logic [7:0] W_SW2_OFF = 8'h53;
    localparam logic [7:0] W_OFS_ON = 8'h54;
    localparam logic [7:0] W_OFS_OFF = 8'h55;
    localparam logic [7:0] W_OFS_NORM = 8'h56;
    localparam logic [7:0] W_V12_ON = 8'h58;
    localparam logic [7:0] W_V12_OFF = 8'h59;
    localparam logic [7:0] W_BELT_ON = 8'h61;
    localparam logic [7:0] W_BELT_OFF = 8'h62;
    // Regulator modes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_SPEED = 3'h1;
    localparam logic [2:0] MODE_TORQUE = 3'h2;
    localparam logic [2:0] MODE_ROAD = 3'h3;
    localparam logic [2:0] MODE_STEADY = 3'h4;
    localparam logic [2:0] MODE_VARLOAD = 3'h5;
    // Auto-offset modes
    localparam logic [1:0] OFS_NORMAL = 2'h0;
    localparam logic [1:0] OFS_ON = 2'h1;
    localparam logic [1:0] OFS_OFF = 2'h2;
    // Actuator pulse positions
    localparam int P_BEAM_UP = 0;
    localparam int P_BEAM_DN = 1;
    localparam int P_REST_UP = 2;
    localparam int P_REST_DN = 3;
    localparam int P_REST_STOP = 4;
    localparam int P_DIST_RST = 5;
    localparam int P_CAL_ZERO = 6;
    localparam int P_CAL_GAIN = 7;
    localparam int P_CAL_STORE = 8;
    localparam int N_PULSE = 9;
    // Event bits
    localparam int IRQ_ACK = 0;
    localparam int IRQ_NAK = 1;
    localparam int IRQ_LOCK = 2;
    localparam int IRQ_FRAME = 3;
    localparam int IRQ_W = 4;
    // Register byte addresses and fields
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATE = 8'h04;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADR_BEAM_FLAG = 8'h10;
    localparam logic [7:0] ADR_LAST_WORD = 8'h14;
    localparam int CTRL_EN_BIT = 8;
    localparam logic [8:0] CTRL_RST = 9'h1_b4;
    // Frame receive states
    typedef enum logic [1:0] {FR_ADDR, FR_SIGN, FR_WORD} dcwi_frame_t;
endpackage

// ===== dcwi_top.sv
// Control word interpreter for the dynamometer host link
`timescale 1ns/1ps
`default_nettype none
module dcwi_top (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Host link bytes
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    // Test stand status
    input wire logic i_rollers_stopped,
    input wire logic i_beam_down,
    // Actuator levels and pulses
    output logic [2:0] o_reg_mode,
    output logic o_aug_brake,
    output logic o_sw1_en,
    output logic o_sw2_en,
    output logic o_brake_test,
    output logic o_supply12,
    output logic o_belt_comp,
    output logic [1:0] o_offset_mode,
    output logic o_motor_on,
    output logic [dcwi_pkg::N_PULSE-1:0] o_act_pulse,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Interrupt
    output logic o_irq
);
    logic [8:0] ctrl_q, ctrl_d;
    logic [7:0] beam_flag_q, beam_flag_d;
    logic [7:0] last_q, last_d;
    logic [31:0] rdata_d;
    logic word_valid;
    logic [7:0] word;
    logic addr_ok;
    logic sign_ok;
    logic frame_ok;
    logic defined;
    logic need_stop;
    logic need_beam;
    logic lock_ok;
    logic accept;
    logic [dcwi_pkg::IRQ_W-1:0] ev_set;
    logic [dcwi_pkg::IRQ_W-1:0] irq_stat;
    logic [dcwi_pkg::IRQ_W-1:0] irq_mask;
    logic [11:0] state_rd;
    logic tx_valid_d;
    logic [7:0] tx_data_d;
    logic [2:0] mode_d, mode_t;
    logic aug_d, aug_t;
    logic sw1_d, sw1_t;
    logic sw2_d, sw2_t;
    logic btest_d, btest_t;
    logic v12_d, v12_t;
    logic belt_d, belt_t;
    logic [1:0] ofs_d, ofs_t;
    logic motor_d, motor_t;
    logic [dcwi_pkg::N_PULSE-1:0] pulse_d, pulse_t;

    dcwi_framer u_framer (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_en(ctrl_q[dcwi_pkg::CTRL_EN_BIT]),
        .i_unit_addr(ctrl_q[7:0]),
        .i_rx_valid(i_rx_valid),
        .i_rx_data(i_rx_data),
        .o_word_valid(word_valid),
        .o_word(word),
        .o_addr_ok(addr_ok),
        .o_sign_ok(sign_ok)
    );

    assign frame_ok = addr_ok && sign_ok;

    // Decode: the tentative effect is only committed once the interlock holds
    always_comb begin
        defined = 1'b1;
        need_stop = 1'b0;
        need_beam = 1'b0;
        mode_t = o_reg_mode;
        aug_t = o_aug_brake;
        sw1_t = o_sw1_en;
        sw2_t = o_sw2_en;
        btest_t = o_brake_test;
        v12_t = o_supply12;
        belt_t = o_belt_comp;
        ofs_t = o_offset_mode;
        motor_t = o_motor_on;
        pulse_t = '0;
        case (word)
            dcwi_pkg::W_REG_OFF: mode_t = dcwi_pkg::MODE_OFF;
            dcwi_pkg::W_SPEED: mode_t = dcwi_pkg::MODE_SPEED;
            dcwi_pkg::W_TORQUE: mode_t = dcwi_pkg::MODE_TORQUE;
            dcwi_pkg::W_ROAD: mode_t = dcwi_pkg::MODE_ROAD;
            dcwi_pkg::W_STEADY: mode_t = dcwi_pkg::MODE_STEADY;
            dcwi_pkg::W_VARLOAD: mode_t = dcwi_pkg::MODE_VARLOAD;
            dcwi_pkg::W_DIST_RST: pulse_t[dcwi_pkg::P_DIST_RST] = 1'b1;
            dcwi_pkg::W_AUG_ON: aug_t = 1'b1;
            dcwi_pkg::W_AUG_OFF: aug_t = 1'b0;
            dcwi_pkg::W_SW1_ON: sw1_t = 1'b1;
            dcwi_pkg::W_SW1_OFF: sw1_t = 1'b0;
            dcwi_pkg::W_SW2_ON: sw2_t = 1'b1;
            dcwi_pkg::W_SW2_OFF: sw2_t = 1'b0;
            dcwi_pkg::W_BTEST_ON: btest_t = 1'b1;
            dcwi_pkg::W_BTEST_OFF: btest_t = 1'b0;
            dcwi_pkg::W_OFS_ON: ofs_t = dcwi_pkg::OFS_ON;
            dcwi_pkg::W_OFS_OFF: ofs_t = dcwi_pkg::OFS_OFF;
            dcwi_pkg::W_OFS_NORM: ofs_t = dcwi_pkg::OFS_NORMAL;
            dcwi_pkg::W_V12_ON: v12_t = 1'b1;
            dcwi_pkg::W_V12_OFF: v12_t = 1'b0;
            dcwi_pkg::W_BELT_ON: belt_t = 1'b1;
            dcwi_pkg::W_BELT_OFF: belt_t = 1'b0;
            dcwi_pkg::W_CAL_STORE: pulse_t[dcwi_pkg::P_CAL_STORE] = 1'b1;
            dcwi_pkg::W_MOTOR_OFF: motor_t = 1'b0;
            dcwi_pkg::W_MOTOR_ON: begin
                motor_t = 1'b1;
                need_stop = 1'b1;
                need_beam = 1'b1;
            end
            dcwi_pkg::W_BEAM_UP, dcwi_pkg::W_BEAM_DN, dcwi_pkg::W_REST_UP, dcwi_pkg::W_REST_DN,
            dcwi_pkg::W_REST_STOP, dcwi_pkg::W_CAL_ZERO, dcwi_pkg::W_CAL_GAIN: begin
                need_stop = 1'b1;
                pulse_t[dcwi_pkg::P_BEAM_UP] = (word == dcwi_pkg::W_BEAM_UP);
                pulse_t[dcwi_pkg::P_BEAM_DN] = (word == dcwi_pkg::W_BEAM_DN);
                pulse_t[dcwi_pkg::P_REST_UP] = (word == dcwi_pkg::W_REST_UP);
                pulse_t[dcwi_pkg::P_REST_DN] = (word == dcwi_pkg::W_REST_DN);
                pulse_t[dcwi_pkg::P_REST_STOP] = (word == dcwi_pkg::W_REST_STOP);
                pulse_t[dcwi_pkg::P_CAL_ZERO] = (word == dcwi_pkg::W_CAL_ZERO);
                pulse_t[dcwi_pkg::P_CAL_GAIN] = (word == dcwi_pkg::W_CAL_GAIN);
            end
            default: defined = 1'b0;
        endcase
        lock_ok = (!need_stop || i_rollers_stopped) && (!need_beam || beam_flag_q == dcwi_pkg::FLAG_TRUE);
        accept = word_valid && frame_ok && defined && lock_ok;
    end

    // Commit and reply
    always_comb begin
        mode_d = o_reg_mode;
        aug_d = o_aug_brake;
        sw1_d = o_sw1_en;
        sw2_d = o_sw2_en;
        btest_d = o_brake_test;
        v12_d = o_supply12;
        belt_d = o_belt_comp;
        ofs_d = o_offset_mode;
        motor_d = o_motor_on;
        pulse_d = '0;
        last_d = last_q;
        tx_valid_d = word_valid;
        tx_data_d = accept ? dcwi_pkg::REPLY_ACK : dcwi_pkg::REPLY_NAK;
        if (word_valid) begin
            last_d = word;
        end
        if (accept) begin
            mode_d = mode_t;
            aug_d = aug_t;
            sw1_d = sw1_t;
            sw2_d = sw2_t;
            btest_d = btest_t;
            v12_d = v12_t;
            belt_d = belt_t;
            ofs_d = ofs_t;
            motor_d = motor_t;
            pulse_d = pulse_t;
        end
        ev_set = '0;
        ev_set[dcwi_pkg::IRQ_ACK] = accept;
        ev_set[dcwi_pkg::IRQ_NAK] = word_valid && !accept;
        ev_set[dcwi_pkg::IRQ_LOCK] = word_valid && frame_ok && defined && !lock_ok;
        ev_set[dcwi_pkg::IRQ_FRAME] = word_valid && !frame_ok;
    end

    // Registers and readback
    assign state_rd = {o_motor_on, o_offset_mode, o_belt_comp, o_supply12, o_brake_test,
                       o_sw2_en, o_sw1_en, o_aug_brake, o_reg_mode};

    always_comb begin
        ctrl_d = ctrl_q;
        beam_flag_d = i_beam_down ? dcwi_pkg::FLAG_TRUE : dcwi_pkg::FLAG_FALSE;
        rdata_d = 32'h0000_0000;
        if (i_wr && i_addr == dcwi_pkg::ADR_CTRL) begin
            ctrl_d = i_wdata[8:0];
        end
        if (i_rd) begin
            case (i_addr)
                dcwi_pkg::ADR_CTRL: rdata_d = {23'h00_0000, ctrl_q};
                dcwi_pkg::ADR_STATE: rdata_d = {20'h0_0000, state_rd};
                dcwi_pkg::ADR_IRQ_STAT: rdata_d = {28'h000_0000, irq_stat};
                dcwi_pkg::ADR_IRQ_MASK: rdata_d = {28'h000_0000, irq_mask};
                dcwi_pkg::ADR_BEAM_FLAG: rdata_d = {24'h00_0000, beam_flag_q};
                dcwi_pkg::ADR_LAST_WORD: rdata_d = {24'h00_0000, last_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    dcwi_irq #(
        .W(dcwi_pkg::IRQ_W)
    ) u_irq (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_set(ev_set),
        .i_clr_we(i_wr && i_addr == dcwi_pkg::ADR_IRQ_STAT),
        .i_mask_we(i_wr && i_addr == dcwi_pkg::ADR_IRQ_MASK),
        .i_wdata(i_wdata[dcwi_pkg::IRQ_W-1:0]),
        .o_stat(irq_stat),
        .o_mask(irq_mask),
        .o_irq(o_irq)
    );

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ctrl_q <= dcwi_pkg::CTRL_RST;
            beam_flag_q <= dcwi_pkg::FLAG_FALSE;
            last_q <= 8'h00;
            o_rdata <= 32'h0000_0000;
            o_tx_valid <= 1'b0;
            o_tx_data <= 8'h00;
            o_reg_mode <= dcwi_pkg::MODE_OFF;
            o_aug_brake <= 1'b0;
            o_sw1_en <= 1'b0;
            o_sw2_en <= 1'b0;
            o_brake_test <= 1'b0;
            o_supply12 <= 1'b0;
            o_belt_comp <= 1'b0;
            o_offset_mode <= dcwi_pkg::OFS_NORMAL;
            o_motor_on <= 1'b0;
            o_act_pulse <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            beam_flag_q <= beam_flag_d;
            last_q <= last_d;
            o_rdata <= rdata_d;
            o_tx_valid <= tx_valid_d;
            o_tx_data <= tx_data_d;
            o_reg_mode <= mode_d;
            o_aug_brake <= aug_d;
            o_sw1_en <= sw1_d;
            o_sw2_en <= sw2_d;
            o_brake_test <= btest_d;
            o_supply12 <= v12_d;
            o_belt_comp <= belt_d;
            o_offset_mode <= ofs_d;
            o_motor_on <= motor_d;
            o_act_pulse <= pulse_d;
        end
    end

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_ack_on_accept: assert property (accept |=> o_tx_valid && o_tx_data == dcwi_pkg::REPLY_ACK)
        else $error("accepted word not acknowledged");
    a_reply_has_cause: assert property (o_tx_valid |-> $past(word_valid))
        else $error("reply without a received word");
    a_nak_holds_state: assert property (word_valid && frame_ok && defined && !lock_ok
        |=> o_tx_data == dcwi_pkg::REPLY_NAK && $stable(o_motor_on) && o_act_pulse == '0)
        else $error("interlocked word executed or acknowledged");
    a_stop_for_pulse: assert property ((|o_act_pulse[dcwi_pkg::P_CAL_GAIN:dcwi_pkg::P_BEAM_UP]
        && !o_act_pulse[dcwi_pkg::P_DIST_RST]) |-> $past(i_rollers_stopped))
        else $error("stand actuator fired while rollers moving");
    a_motor_interlock: assert property ($rose(o_motor_on)
        |-> $past(i_rollers_stopped) && $past(beam_flag_q) == dcwi_pkg::FLAG_TRUE)
        else $error("drive motor started without interlock");
    a_motor_off_free: assert property (word_valid && frame_ok && word == dcwi_pkg::W_MOTOR_OFF
        |=> !o_motor_on ##0 o_tx_data == dcwi_pkg::REPLY_ACK)
        else $error("motor off refused");
    a_steady_free: assert property (word_valid && frame_ok && word == dcwi_pkg::W_STEADY
        |=> o_reg_mode == dcwi_pkg::MODE_STEADY && o_tx_data == dcwi_pkg::REPLY_ACK)
        else $error("steady load word not executed");
    // Reset clears the flag byte, so the first edge after release is left out
    a_beam_flag_byte: assert property ($past(i_rst_n)
        |-> beam_flag_q == ($past(i_beam_down) ? dcwi_pkg::FLAG_TRUE : dcwi_pkg::FLAG_FALSE))
        else $error("beam flag byte wrong");
    a_bad_frame_nak: assert property (word_valid && (!frame_ok || !defined)
        |=> o_tx_valid && o_tx_data == dcwi_pkg::REPLY_NAK && $stable(o_reg_mode))
        else $error("bad frame not refused");
endmodule // dcwi_top
`default_nettype wire

// ===== dcwi_top_tb.sv
// Self-checking bench for the control word interpreter
`timescale 1ns/1ps
`default_nettype none
module dcwi_top_tb;
    typedef struct packed {logic [7:0] rep; logic [8:0] pul; logic [2:0] mode; logic mot; logic [7:0] lv;} dcwi_note_t;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic rx_valid, tx_valid, aug, sw1, sw2, btest, sup12, belt, motor, irq;
    logic [7:0] rx_data, tx_data;
    logic stop = 1'b1;
    logic bdn = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, v;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] mode, mode_m;
    logic [1:0] ofs;
    logic [8:0] pulse;
    logic mot_m, live;
    logic [7:0] lv_m;
    // On and off words of the level outputs, augmented braking first
    logic [7:0] lw [0:11] = '{8'h41, 8'h42, 8'h48, 8'h49, 8'h52, 8'h53,
        8'h4f, 8'h50, 8'h58, 8'h59, 8'h61, 8'h62};
    logic [7:0] pw [0:8] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h47, 8'h39, 8'h4c, 8'h4d, 8'h4e};
    dcwi_note_t q [$];
    dcwi_note_t mon_n;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    always #20 i_mclk = ~i_mclk;

    dcwi_host host_u (.i_mclk(i_mclk), .o_rx_valid(rx_valid), .o_rx_data(rx_data));
    dcwi_top dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
        .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_rollers_stopped(stop), .i_beam_down(bdn),
        .o_reg_mode(mode), .o_aug_brake(aug), .o_sw1_en(sw1), .o_sw2_en(sw2), .o_brake_test(btest),
        .o_supply12(sup12), .o_belt_comp(belt), .o_offset_mode(ofs), .o_motor_on(motor),
        .o_act_pulse(pulse), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_irq(irq));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Reference of reply and effects, tracking mode and motor as the block should
    function automatic dcwi_note_t predict(input logic [7:0] a, input logic [7:0] s, input logic [7:0] w);
        dcwi_note_t n;
        logic ok;
        n = '{rep: dcwi_pkg::REPLY_NAK, pul: 9'h000, mode: mode_m, mot: mot_m, lv: lv_m};
        ok = (w inside {[8'h30:8'h39], 8'h41, 8'h42, [8'h47:8'h56], 8'h58, 8'h59, 8'h61, 8'h62});
        ok = ok && a == dcwi_pkg::UNIT_ADDR_RST && s == dcwi_pkg::CTRL_SIGN;
        if (w inside {[8'h35:8'h38], 8'h47, 8'h4c, 8'h4d}) ok = ok && stop;
        if (w == 8'h4a) ok = ok && stop && bdn;
        if (ok) begin
            n.rep = dcwi_pkg::REPLY_ACK;
            for (int k = 0; k < 9; k++) n.pul[k] = (w == pw[k]);
            if (w inside {[8'h30:8'h34]}) n.mode = w[2:0];
            if (w == 8'h51) n.mode = dcwi_pkg::MODE_VARLOAD;
            if (w == 8'h4a || w == 8'h4b) n.mot = ~w[0];
            for (int k = 0; k < 12; k++) if (w == lw[k]) n.lv[k / 2] = ~k[0];
            if (w == 8'h54) n.lv[7:6] = dcwi_pkg::OFS_ON;
            if (w == 8'h55) n.lv[7:6] = dcwi_pkg::OFS_OFF;
            if (w == 8'h56) n.lv[7:6] = dcwi_pkg::OFS_NORMAL;
        end
        mode_m = n.mode;
        mot_m = n.mot;
        lv_m = n.lv;
        return n;
    endfunction

    task automatic frame(input logic [7:0] a, input logic [7:0] s, input logic [7:0] w, input logic exp);
        if (exp) q.push_back(predict(a, s, w));
        host_u.send(a, s, w);
        repeat (4) @(posedge i_mclk);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_mclk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_mclk);
        rd <= 1'b0;
        @(posedge i_mclk);
        d = rdata;
    endtask

    task automatic levels(input logic s, input logic b);
        @(posedge i_mclk);
        stop <= s;
        bdn <= b;
        repeat (2) @(posedge i_mclk);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Each reply is matched against the oldest note; pulses outside a reply are faults
    always @(posedge i_mclk) begin
        if (live && tx_valid === 1'b1) begin
            if (q.size() == 0) begin
                chk(32'(tx_valid), 32'h0000_0000);
            end else begin
                mon_n = q.pop_front();
                chk(32'(tx_data), 32'(mon_n.rep));
                chk(32'(pulse), 32'(mon_n.pul));
                chk(32'(mode), 32'(mon_n.mode));
                chk(32'(motor), 32'(mon_n.mot));
                chk(32'({ofs, belt, sup12, btest, sw2, sw1, aug}), 32'(mon_n.lv));
            end
        end else if (live && pulse !== 9'h000) begin
            chk(32'(pulse), 32'h0000_0000);
        end
    end

    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        live = 1'b0;
        mode_m = dcwi_pkg::MODE_OFF;
        mot_m = 1'b0;
        lv_m = 8'h00;
        void'($urandom(32'h5e33));
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        live = 1'b1;
        reg_rd(dcwi_pkg::ADR_CTRL, v);
        chk(v, 32'h0000_01b4);
        reg_rd(dcwi_pkg::ADR_IRQ_MASK, v);
        chk(v, 32'h0000_0000);
        reg_rd(8'h20, v);
        chk(v, 32'h0000_0000);
        $display("test registers done");
        // Every word from '/' to 'c', first with rollers stopped, then turning
        for (int r = 0; r < 2; r++) begin
            levels(r == 0, 1'b1);
            for (int w = 8'h2f; w <= 8'h63; w++) frame(8'hb4, 8'h11, 8'(w), 1'b1);
        end
        levels(1'b1, 1'b0);
        frame(8'hb4, 8'h11, dcwi_pkg::W_MOTOR_ON, 1'b1);
        frame(8'hb4, 8'h11, dcwi_pkg::W_MOTOR_OFF, 1'b1);
        reg_rd(dcwi_pkg::ADR_BEAM_FLAG, v);
        chk(v, 32'h0000_0000);
        levels(1'b1, 1'b1);
        reg_rd(dcwi_pkg::ADR_BEAM_FLAG, v);
        chk(v, 32'h0000_0001);
        frame(8'hb4, 8'h11, dcwi_pkg::W_MOTOR_ON, 1'b1);
        frame(8'hb5, 8'h11, dcwi_pkg::W_STEADY, 1'b1);
        frame(8'hb4, 8'h12, dcwi_pkg::W_STEADY, 1'b1);
        $display("test sweep done");
        reg_wr(dcwi_pkg::ADR_IRQ_STAT, 32'h0000_000f);
        reg_wr(dcwi_pkg::ADR_IRQ_MASK, 32'h0000_0002);
        // One more edge so the new mask meets the cleared status
        @(posedge i_mclk);
        chk(32'(irq), 32'h0000_0000);
        frame(8'hb4, 8'h11, 8'h5a, 1'b1);
        chk(32'(irq), 32'h0000_0001);
        reg_rd(dcwi_pkg::ADR_IRQ_STAT, v);
        chk(v, 32'h0000_0002);
        reg_wr(dcwi_pkg::ADR_IRQ_STAT, 32'h0000_0002);
        repeat (2) @(posedge i_mclk);
        chk(32'(irq), 32'h0000_0000);
        $display("test interrupt done");
        // Disabled link ignores a whole frame, then framing restarts cleanly
        reg_wr(dcwi_pkg::ADR_CTRL, 32'h0000_00b4);
        frame(8'hb4, 8'h11, dcwi_pkg::W_STEADY, 1'b0);
        reg_wr(dcwi_pkg::ADR_CTRL, 32'h0000_01b4);
        frame(8'hb4, 8'h11, dcwi_pkg::W_DIST_RST, 1'b1);
        reg_rd(dcwi_pkg::ADR_LAST_WORD, v);
        chk(v, 32'h0000_0039);
        $display("test enable done");
        for (int i = 0; i < 30; i++) begin
            levels(1'($urandom), 1'($urandom));
            frame(($urandom % 4 == 0) ? 8'($urandom) : 8'hb4, ($urandom % 5 == 0) ? 8'($urandom) : 8'h11,
                8'(8'h2c + $urandom % 60), 1'b1);
        end
        $display("test random done");
        chk(32'(q.size()), 32'h0000_0000);
        complete_run();
    end
endmodule // dcwi_top_tb
`default_nettype wire
